/* File: design/gcswl_pkg.sv */
// Package with constants and carriers of the gain control serial word loader.
package gcswl_pkg;

  localparam int WORD_BITS = 16;
  localparam int CNT_W     = 5;

  // Bit numbers as counted on the bus: bit 1 is the first bit shifted in.
  localparam int PGC_FIRST_BIT = 1;
  localparam int PGC_LAST_BIT  = 13;
  localparam int AREF_BIT      = 14;
  localparam int LNA_GAIN_BIT  = 15;
  localparam int SPARE_BIT     = 16;

  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [4:0]  CNT_RESET   = 5'h00;
  localparam logic [4:0]  CNT_FULL    = 5'h10;
  localparam logic [1:0]  DIV3_LAST   = 2'h2;

  typedef enum logic [1:0] {
    GCSWL_IDLE  = 2'b00,
    GCSWL_SHIFT = 2'b01
  } gcswl_state_t;

  // Decoded settings of the control word.
  typedef struct packed {
    logic [12:0] if_gain_code;
    logic        lna_ref_on;
    logic        lna_high_gain;
  } gcswl_ctrl_t;

  // Static power switches.
  typedef struct packed {
    logic rf_on;
    logic if_on;
    logic osc_on;
  } gcswl_power_t;

endpackage

/* File: design/gcswl_osc_divider.sv */
// Oscillator path: divide by 1 or 3, then quadrature phases at a quarter of that rate.
`timescale 1ns/1ps
module gcswl_osc_divider (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // Control
  input  wire logic i_enable,
  input  wire logic i_divider_select,
  // Outputs
  output logic      o_buffered_clk_en,
  output logic      o_phase_i,
  output logic      o_phase_q
);

  logic [1:0] div3_r;
  logic [1:0] div3_nxt;
  logic       tick;
  logic       i_r;
  logic       i_nxt;
  logic       q_r;
  logic       q_nxt;
  logic       step_r;
  logic       step_nxt;

  // The core clock stands in for the oscillator; tick marks each
  // buffered-output cycle, so divide-by-1 ticks every cycle.
  // divider select
  always_comb begin
    div3_nxt = div3_r;
    tick     = 1'b0;
    if (!i_enable) begin
      div3_nxt = 2'h0;
    end else if (!i_divider_select) begin
      div3_nxt = 2'h0;
      tick     = 1'b1;
    end else if (div3_r == gcswl_pkg::DIV3_LAST) begin
      div3_nxt = 2'h0;
      tick     = 1'b1;
    end else begin
      div3_nxt = div3_r + 2'h1;
    end
  end

  always_comb begin
    i_nxt    = i_r;
    q_nxt    = q_r;
    step_nxt = step_r;
    if (!i_enable) begin
      i_nxt    = 1'b0;
      q_nxt    = 1'b0;
      step_nxt = 1'b0;
    end else if (tick) begin
      step_nxt = ~step_r;
      if (step_r) begin
        q_nxt = i_r;
      end else begin
        i_nxt = ~q_r;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      div3_r <= 2'h0;
      i_r    <= 1'b0;
      q_r    <= 1'b0;
      step_r <= 1'b0;
    end else begin
      div3_r <= div3_nxt;
      i_r    <= i_nxt;
      q_r    <= q_nxt;
      step_r <= step_nxt;
    end
  end

  assign o_buffered_clk_en = tick;
  assign o_phase_i         = i_r;
  assign o_phase_q         = q_r;

endmodule

/* File: design/gcswl_top.sv */
// Control logic: three-wire word loader, gain decode, power and divider.
`timescale 1ns/1ps
// Functional notes
// - A 16-bit word is shifted in and captured into the gain register.
// - Bits arrive first bit first, one per serial clock rising edge.
// - IF power off clears the gain register; the controller must reload.
// - Bits 1 to 13 set IF gain, all ones 70 dB, zeros -10 dB.
// - Bit 14 turns the amplifier reference on when one.
// - With reference on, bit 15 picks high or low amplifier gain.
// - Each power input switches its section on when high.
// - Divider select low passes oscillator straight, high divides by three.
// - Selected oscillator is divided by four into in-phase and quadrature phases.
// - Bus is serial data, serial clock and enable, all from controller.
module gcswl_top #(
  parameter int WORD_BITS = gcswl_pkg::WORD_BITS
) (
  // Clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  // Three-wire bus
  input  wire logic                 i_serial_data_in,
  input  wire logic                 i_serial_clock_in,
  input  wire logic                 i_serial_enable_in,
  // Static control pins
  input  wire logic                 i_rf_power_on,
  input  wire logic                 i_if_power_on,
  input  wire logic                 i_osc_power_on,
  input  wire logic                 i_divider_select,
  // Decoded settings
  output gcswl_pkg::gcswl_ctrl_t    o_ctrl,
  output logic [WORD_BITS-1:0]      o_gain_control_word,
  output gcswl_pkg::gcswl_power_t   o_power,
  output logic                      o_load_strobe,
  // Oscillator path
  output logic                      o_buffered_clk_en,
  output logic                      o_phase_i,
  output logic                      o_phase_q
);

  gcswl_pkg::gcswl_state_t state_r;
  gcswl_pkg::gcswl_state_t state_nxt;
  logic [WORD_BITS-1:0]    shift_r;
  logic [WORD_BITS-1:0]    shift_nxt;
  logic [WORD_BITS-1:0]    word_r;
  logic [WORD_BITS-1:0]    word_nxt;
  logic [4:0]              cnt_r;
  logic [4:0]              cnt_nxt;
  logic                    sclk_d_r;
  logic                    load_r;
  logic                    load_nxt;
  logic                    sclk_rise;

  // Bus pins are synchronous to the core clock, so a plain edge detect works.
  assign sclk_rise = i_serial_clock_in & ~sclk_d_r;

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    word_nxt  = word_r;
    cnt_nxt   = cnt_r;
    load_nxt  = 1'b0;
    case (state_r)
      gcswl_pkg::GCSWL_IDLE: begin
        if (i_serial_enable_in) begin
          state_nxt = gcswl_pkg::GCSWL_SHIFT;
          cnt_nxt   = gcswl_pkg::CNT_RESET;
          shift_nxt = gcswl_pkg::WORD_RESET;
          if (sclk_rise) begin
            shift_nxt = {gcswl_pkg::WORD_RESET[WORD_BITS-2:0],
                         i_serial_data_in};
            cnt_nxt   = 5'h01;
          end
        end
      end
      gcswl_pkg::GCSWL_SHIFT: begin
        if (!i_serial_enable_in) begin
          state_nxt = gcswl_pkg::GCSWL_IDLE;
          if (cnt_r == gcswl_pkg::CNT_FULL) begin
            word_nxt = shift_r;
            load_nxt = 1'b1;
          end
        end else if (sclk_rise && cnt_r != gcswl_pkg::CNT_FULL) begin
          shift_nxt = {shift_r[WORD_BITS-2:0], i_serial_data_in};
          cnt_nxt   = cnt_r + 5'h01;
        end
      end
      default: begin
        state_nxt = gcswl_pkg::GCSWL_IDLE;
      end
    endcase
    if (!i_if_power_on) begin
      word_nxt  = gcswl_pkg::WORD_RESET;
      load_nxt  = 1'b0;
      state_nxt = gcswl_pkg::GCSWL_IDLE;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r  <= gcswl_pkg::GCSWL_IDLE;
      shift_r  <= gcswl_pkg::WORD_RESET;
      word_r   <= gcswl_pkg::WORD_RESET;
      cnt_r    <= gcswl_pkg::CNT_RESET;
      sclk_d_r <= 1'b0;
      load_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      shift_r  <= shift_nxt;
      word_r   <= word_nxt;
      cnt_r    <= cnt_nxt;
      sclk_d_r <= i_serial_clock_in;
      load_r   <= load_nxt;
    end
  end

  // Bus bit n lands at word index WORD_BITS-n, so bit 1 is the MSB.
  // IF gain field
  assign o_ctrl.if_gain_code =
    word_r[WORD_BITS-gcswl_pkg::PGC_FIRST_BIT:
           WORD_BITS-gcswl_pkg::PGC_LAST_BIT];
  assign o_ctrl.lna_ref_on = word_r[WORD_BITS-gcswl_pkg::AREF_BIT];
  assign o_ctrl.lna_high_gain = word_r[WORD_BITS-gcswl_pkg::AREF_BIT]
                              & word_r[WORD_BITS-gcswl_pkg::LNA_GAIN_BIT];
  assign o_gain_control_word = word_r;
  assign o_load_strobe       = load_r;

  assign o_power.rf_on  = i_rf_power_on;
  assign o_power.if_on  = i_if_power_on;
  assign o_power.osc_on = i_osc_power_on;

  gcswl_osc_divider u_osc (
    .i_core_clk        (i_core_clk),
    .i_rst             (i_rst),
    .i_enable          (i_osc_power_on),
    .i_divider_select  (i_divider_select),
    .o_buffered_clk_en (o_buffered_clk_en),
    .o_phase_i         (o_phase_i),
    .o_phase_q         (o_phase_q)
  );

endmodule

/* File: testbench/gcswl_properties.sv */
// Port checker of the word loader, bound to the top module.
`timescale 1ns/1ps
module gcswl_properties #(
  parameter int WORD_BITS = gcswl_pkg::WORD_BITS
) (
  // Clock, reset and pins
  input wire logic                    i_core_clk,
  input wire logic                    i_rst,
  input wire logic                    i_serial_enable_in,
  input wire logic                    i_rf_power_on,
  input wire logic                    i_if_power_on,
  input wire logic                    i_osc_power_on,
  input wire logic                    i_divider_select,
  // Outputs
  input wire gcswl_pkg::gcswl_ctrl_t  o_ctrl,
  input wire logic [WORD_BITS-1:0]    o_gain_control_word,
  input wire gcswl_pkg::gcswl_power_t o_power,
  input wire logic                    o_load_strobe,
  input wire logic                    o_buffered_clk_en,
  input wire logic                    o_phase_i,
  input wire logic                    o_phase_q
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_if_off;
    !i_if_power_on ##1 1'b1;
  endsequence
  sequence s_div3_tick;
    i_osc_power_on && i_divider_select && o_buffered_clk_en;
  endsequence
  a_if_clear:
    assert property (s_if_off |-> o_gain_control_word == '0)
    else $error("word kept");
  a_load_release:
    assert property (o_load_strobe |-> !$past(i_serial_enable_in))
    else $error("load in frame");
  a_word_hold:
    assert property ($changed(o_gain_control_word) |-> o_load_strobe
      || !$past(i_if_power_on) || $past(i_rst)) else $error("word moved");
  a_gain_decode:
    assert property (o_ctrl.if_gain_code == o_gain_control_word[15:3])
    else $error("gain code");
  a_lna_bits:
    assert property (o_ctrl.lna_ref_on == o_gain_control_word[2] &&
      o_ctrl.lna_high_gain == &o_gain_control_word[2:1]) else $error("lna");
  a_power_copy:
    assert property (o_power == {i_rf_power_on, i_if_power_on,
      i_osc_power_on}) else $error("power");
  a_div_three:
    assert property (s_div3_tick ##1 (i_osc_power_on && i_divider_select)
      |-> !o_buffered_clk_en) else $error("div3");
  a_quad_order:
    assert property ($rose(o_phase_q) |-> o_phase_i) else $error("quad");
endmodule

bind gcswl_top gcswl_properties #(.WORD_BITS(WORD_BITS)) u_props (
  .i_core_clk, .i_rst, .i_serial_enable_in, .i_rf_power_on, .i_if_power_on,
  .i_osc_power_on, .i_divider_select, .o_ctrl, .o_gain_control_word,
  .o_power, .o_load_strobe, .o_buffered_clk_en, .o_phase_i, .o_phase_q);

/* File: testbench/gcswl_ctrl_model.sv */
// Controller model that shifts control words over the three-wire bus.
`timescale 1ns/1ps
module gcswl_ctrl_model (
  // Clock
  input  wire logic i_core_clk,
  // Three-wire bus
  output logic      o_serial_data_in,
  output logic      o_serial_clock_in,
  output logic      o_serial_enable_in
);
  initial begin
    o_serial_data_in   = 1'b0;
    o_serial_clock_in  = 1'b0;
    o_serial_enable_in = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int n);
    @(negedge i_core_clk);
    o_serial_enable_in = 1'b1;
    for (int k = 0; k < n; k++) begin
      @(negedge i_core_clk);
      o_serial_data_in = (k < 16) ? w[15-k] : ~w[0];
      @(negedge i_core_clk);
      o_serial_clock_in = 1'b1;
      @(negedge i_core_clk);
      o_serial_clock_in = 1'b0;
    end
    @(negedge i_core_clk);
    o_serial_enable_in = 1'b0;
    // Released data flips so a stale bit never looks like a held one.
    o_serial_data_in = ~o_serial_data_in;
  endtask
endmodule

/* File: testbench/gain_control_serial_word_loader_tb.sv */
// Self-checking bench of the gain control serial word loader.
`timescale 1ns/1ps
module gain_control_serial_word_loader_tb;
  logic i_core_clk, i_rst, i_serial_data_in, i_serial_clock_in;
  logic i_serial_enable_in, i_rf_power_on, i_if_power_on;
  logic i_osc_power_on, i_divider_select;
  logic o_load_strobe, o_buffered_clk_en, o_phase_i, o_phase_q;
  gcswl_pkg::gcswl_ctrl_t  o_ctrl;
  gcswl_pkg::gcswl_power_t o_power;
  logic [15:0]             o_gain_control_word, seed, w_exp, cnt, ph;
  logic [15:0]             exp_q[$];
  int                      n_fail, tests_run;

  gcswl_top u_dut (.i_core_clk, .i_rst, .i_serial_data_in,
    .i_serial_clock_in, .i_serial_enable_in, .i_rf_power_on,
    .i_if_power_on, .i_osc_power_on, .i_divider_select, .o_ctrl,
    .o_gain_control_word, .o_power, .o_load_strobe, .o_buffered_clk_en,
    .o_phase_i, .o_phase_q);
  gcswl_ctrl_model u_ctl (.i_core_clk, .o_serial_data_in(i_serial_data_in),
    .o_serial_clock_in(i_serial_clock_in),
    .o_serial_enable_in(i_serial_enable_in));

  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  function automatic logic [15:0] xs(input logic [15:0] v);
    logic [15:0] t;
    t = v ^ (v << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Only full frames are noted, so a short frame that loads shows up here.
  // Bits beyond the sixteenth are dropped, so a long frame loads the word.
  task automatic load(input int n);
    seed = xs(seed);
    if (n >= 16) exp_q.push_back(seed);
    u_ctl.send(seed, n);
    repeat (4) @(negedge i_core_clk);
  endtask

  always @(negedge i_core_clk) begin
    if (!i_rst && o_load_strobe !== 1'b0) begin
      if (exp_q.size() == 0) chk("extra load", 16'h0000, 16'h0001);
      else begin
        w_exp = exp_q.pop_front();
        chk("word", w_exp, o_gain_control_word);
        chk("ctrl", {1'b0, w_exp[15:2], &w_exp[2:1]}, 16'(o_ctrl));
      end
    end
  end

  initial begin
    n_fail = 0;
    tests_run = 0;
    seed = 16'hb2be;
    i_rst = 1'b1;
    {i_rf_power_on, i_if_power_on, i_osc_power_on} = 3'h7;
    i_divider_select = 1'b0;
    repeat (8) @(negedge i_core_clk);
    i_rst = 1'b0;
    for (int k = 0; k < 6; k++) load(16);
    load(17);
    load(15);
    i_if_power_on = 1'b0;
    @(negedge i_core_clk);
    i_if_power_on = 1'b1;
    @(negedge i_core_clk);
    chk("cleared", 16'h0000, o_gain_control_word);
    for (int k = 0; k < 8; k++) begin
      {i_rf_power_on, i_osc_power_on, i_divider_select} = 3'(k);
      cnt = 16'h0000;
      ph  = 16'h0000;
      repeat (6) begin
        @(negedge i_core_clk);
        cnt = cnt + 16'(o_buffered_clk_en);
        ph  = ph + 16'(o_phase_i);
      end
      chk("power", {13'h0, 3'(k) | 3'h2} & 16'hfffe |
        16'(i_osc_power_on), 16'(o_power));
      chk("ticks", !i_osc_power_on ? 16'h0 : i_divider_select ? 16'h2 :
        16'h6, cnt);
      // In-phase output is high two ticks in four, so div3 shows less.
      chk("phase", !i_osc_power_on ? 16'h0 : i_divider_select ? 16'h2 :
        16'h4, ph);
    end
    load(16);
    for (int t = 0; t < 50 && exp_q.size() > 0; t++) @(negedge i_core_clk);
    if (exp_q.size() > 0) chk("pending", 16'h0000, 16'(exp_q.size()));
    test_done();
  end
endmodule
